// *** hdl/host_port_device.sv ***
/*
  device end: pairs two 16-bit accesses into one 32-bit word, applies the
  word swap setting, commits writes only when whole.
  assumes the user side answers reads combinationally from word_rdata.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pair_params.svh"
module host_port_device
  import pair_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  host_port_if.device bus,
  input wire word_t word_swap, // swap setting
  output var waddr_t word_addr_out, // address of committed access
  output var word_t word_wdata, // assembled write word
  output var logic word_we, // one-cycle commit of a whole write
  output var logic word_re, // one-cycle pulse: first read half fetches word
  input wire word_t word_rdata, // word at word_addr_out, given the cycle word_re is high
  output var logic read_restart // pulse: repeated read half seen
);
  typedef struct packed {
    logic wr_pend; // one write half held
    logic wr_hi; // which logical half held
    half_t wr_half; // held write half
    logic rd_pend; // one read half taken
    logic rd_hi; // which half was read
    logic fetch; // capture word next cycle
    logic fetch_hi; // logical half to return
    word_t rd_word; // latched read word
    half_t rdata;
    logic rvalid;
    waddr_t addr;
    word_t wword;
    logic we;
    logic re;
    logic restart;
  } dev_s;
  dev_s s_reg, s_next;
  logic swapped; // all ones selects swap mode
  logic hi_word; // logical half addressed
  // swap mode only for exactly all ones, any other value is default
  assign swapped = (word_swap == `SWAP_ALL_ONES);
  assign hi_word = bus.half_select_address_bit ^ swapped;
  // next-state logic for pairing
  always_comb begin
    s_next = s_reg;
    s_next.we = 1'b0;
    s_next.re = 1'b0;
    s_next.rvalid = 1'b0;
    s_next.restart = 1'b0;
    s_next.fetch = 1'b0;
    // word fetched last cycle: keep it and answer the first half
    if (s_reg.fetch) begin
      s_next.rd_word = word_rdata;
      s_next.rdata = s_reg.fetch_hi ? word_rdata[`WORD_W-1:`HALF_W]
        : word_rdata[`HALF_W-1:0];
      s_next.rvalid = 1'b1;
    end
    if (bus.cs && bus.we) begin
      if (!s_reg.wr_pend) begin
        // first half, held only
        s_next.wr_pend = 1'b1;
        s_next.wr_hi = hi_word;
        s_next.wr_half = bus.wdata;
        s_next.addr = bus.word_addr;
      end else if (s_reg.wr_hi == hi_word) begin
        s_next.wr_pend = s_reg.wr_pend; // same half: dropped, held half kept
      end else begin
        // other half: either order forms the word
        s_next.wr_pend = 1'b0;
        s_next.wword = hi_word ? {bus.wdata, s_reg.wr_half} : {s_reg.wr_half, bus.wdata};
        s_next.we = 1'b1;
      end
    end else if (bus.cs) begin
      if (s_reg.rd_pend && (s_reg.rd_hi == hi_word)) begin
        // same half twice: answer stale data, restart pairing
        s_next.rd_pend = 1'b0;
        s_next.restart = 1'b1;
        s_next.rdata = hi_word ? s_reg.rd_word[`WORD_W-1:`HALF_W]
          : s_reg.rd_word[`HALF_W-1:0];
        s_next.rvalid = 1'b1;
      end else if (!s_reg.rd_pend) begin
        // first half: fetch whole word once so halves stay coherent
        s_next.rd_pend = 1'b1;
        s_next.rd_hi = hi_word;
        s_next.addr = bus.word_addr;
        s_next.re = 1'b1;
        s_next.fetch = 1'b1;
        s_next.fetch_hi = hi_word;
      end else begin
        // second half comes from the latched word
        s_next.rd_pend = 1'b0;
        s_next.rdata = hi_word ? s_reg.rd_word[`WORD_W-1:`HALF_W]
          : s_reg.rd_word[`HALF_W-1:0];
        s_next.rvalid = 1'b1;
      end
    end
  end
  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign bus.rdata = s_reg.rdata;
  assign bus.rvalid = s_reg.rvalid;
  assign word_addr_out = s_reg.addr;
  assign word_wdata = s_reg.wword;
  assign word_we = s_reg.we;
  assign word_re = s_reg.re;
  assign read_restart = s_reg.restart;
endmodule // host_port_device
`default_nettype wire

// *** hdl/pair_params.svh ***
/*
  constants for the 16-bit host port that pairs halves into 32-bit words.
  assumes inclusion by bare name from the package and both ends.
*/
`ifndef PAIR_PARAMS_SVH
`define PAIR_PARAMS_SVH
`define HALF_W 16
`define WORD_W 32
`define ADDR_W 8
`define SWAP_ALL_ONES 32'hffffffff
`define WORD_RESET 32'h00000000
`define HALF_RESET 16'h0000
`endif

// *** hdl/pair_pkg.sv ***
/*
  types shared by both ends of the host port.
  assumes pair_params.svh is on the include path.
*/
`include "pair_params.svh"
package pair_pkg;
  typedef logic [`HALF_W-1:0] half_t;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`ADDR_W-1:0] waddr_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_half = 2'b01,
    st_done = 2'b10
  } pair_state_e;
endpackage

// *** hdl/host_port_if.sv ***
/*
  bus between the host end and the device end: one access per strobe.
  assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
  import pair_pkg::*;
  logic cs; // one-cycle access strobe
  logic we; // write when high
  waddr_t word_addr; // address bits 2 and up
  logic half_select_address_bit; // half select
  half_t wdata; // write half
  half_t rdata; // read half, valid two cycles after the first read strobe of a pair, one cycle after the second
  logic rvalid; // read answer pulse
  modport host (output cs, output we, output word_addr, output half_select_address_bit,
    output wdata, input rdata, input rvalid);
  modport device (input cs, input we, input word_addr, input half_select_address_bit,
    input wdata, output rdata, output rvalid);
endinterface
`default_nettype wire

// *** hdl/host_port_host.sv ***
/*
  host end: splits a 32-bit request into two 16-bit accesses to one word,
  the physical half named by req_first_hi first.
  assumes the device answers each read with one rvalid pulse, one or two cycles after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pair_params.svh"
module host_port_host
  import pair_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  host_port_if.host bus,
  input wire logic req, // start a word access when ready
  input wire logic req_we,
  input wire waddr_t req_addr,
  input wire word_t req_wdata,
  input wire logic req_first_hi, // physical half to access first
  output var logic ready, // idle, request taken when req high
  output var logic done, // pulse: access complete
  output var word_t rd_word // read result, valid with done
);
  typedef struct packed {
    pair_state_e st;
    logic phase; // 0 first half, 1 second
    logic we;
    logic first_hi;
    waddr_t addr;
    word_t wdata;
    word_t rword;
    logic cs;
    logic sel;
    half_t bus_w;
    logic wait_rd; // read answer outstanding
    logic done;
    logic rdy; // registered idle flag, so ready comes from a flop
  } host_s;
  host_s h_reg, h_next;
  // sequence two halves of one word
  always_comb begin
    h_next = h_reg;
    h_next.cs = 1'b0;
    h_next.done = 1'b0;
    case (h_reg.st)
      st_idle: begin
        // take a request only while ready is shown, never in reset's wake
        if (req && h_reg.rdy) begin
          h_next.st = st_half;
          h_next.phase = 1'b0;
          h_next.we = req_we;
          h_next.first_hi = req_first_hi;
          h_next.addr = req_addr; // held for both halves
          h_next.wdata = req_wdata;
        end
      end
      st_half: begin
        if (!h_reg.wait_rd && !h_reg.cs) begin
          // issue one half; second targets the other half
          h_next.cs = 1'b1;
          h_next.sel = h_reg.first_hi ^ h_reg.phase;
          h_next.bus_w = (h_reg.first_hi ^ h_reg.phase) ? h_reg.wdata[`WORD_W-1:`HALF_W]
            : h_reg.wdata[`HALF_W-1:0];
          h_next.wait_rd = !h_reg.we;
          if (h_reg.we && h_reg.phase) begin
            h_next.st = st_done;
          end
          if (h_reg.we) begin
            h_next.phase = 1'b1;
          end
        end else if (h_reg.wait_rd && bus.rvalid) begin
          h_next.wait_rd = 1'b0;
          if (h_reg.sel) begin
            h_next.rword[`WORD_W-1:`HALF_W] = bus.rdata;
          end else begin
            h_next.rword[`HALF_W-1:0] = bus.rdata;
          end
          h_next.phase = 1'b1;
          if (h_reg.phase) begin
            h_next.st = st_done;
          end
        end
      end
      st_done: begin
        h_next.st = st_idle;
        h_next.done = 1'b1;
      end
      default: begin
        h_next.st = st_idle;
      end
    endcase
    // ready tracks the next state so it stands in step with st_idle
    h_next.rdy = (h_next.st == st_idle);
  end
  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end
  assign bus.cs = h_reg.cs;
  assign bus.we = h_reg.we;
  assign bus.word_addr = h_reg.addr;
  assign bus.half_select_address_bit = h_reg.sel;
  assign bus.wdata = h_reg.bus_w;
  assign ready = h_reg.rdy;
  assign done = h_reg.done;
  assign rd_word = h_reg.rword;
endmodule // host_port_host
`default_nettype wire

// *** verif/host_port_chk.sv ***
/* checker on the bus between the two ends of the host port.
   assumes the bench passes the bus signals in by name. */
`timescale 1ns/100ps
`default_nettype none
module host_port_chk
  import pair_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs,
  input wire logic we,
  input wire waddr_t word_addr,
  input wire logic half_select_address_bit,
  input wire half_t rdata,
  input wire logic rvalid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rd_reg, wr_reg, hs_reg; // open read pair, open write pair, its half
  waddr_t wa_reg; // word of the open pair
  // pair tracking, exact only because this host never repeats a half
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {rd_reg, wr_reg, hs_reg} <= 3'h0;
      wa_reg <= '0;
    end else if (cs) begin
      {rd_reg, wr_reg, hs_reg} <= {rd_reg ^ !we, wr_reg ^ we, half_select_address_bit};
      wa_reg <= word_addr;
    end
  end
  pair_a: assert property (cs && (we ? wr_reg : rd_reg) |->
    word_addr == wa_reg && half_select_address_bit != hs_reg) else $error("bad pair");
  wr_next_a: assert property (cs && we && !wr_reg |-> ##2 cs && we)
    else $error("write pair gap");
  rd_next_a: assert property (cs && !we && !rd_reg |-> ##[3:8] cs && !we)
    else $error("read pair left open");
  rd_first_a: assert property (cs && !we && !rd_reg |=> !rvalid ##1 rvalid)
    else $error("first answer late");
  rd_second_a: assert property (cs && !we && rd_reg |=> rvalid)
    else $error("second answer late");
  rv_cause_a: assert property (rvalid |-> $past(cs && !we) || $past(cs && !we, 2))
    else $error("stray answer");
  rv_pulse_a: assert property (rvalid |=> !rvalid)
    else $error("long answer");
  rd_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved");
endmodule // host_port_chk
`default_nettype wire

// *** verif/tb.sv ***
/* bench: host end against device end, plus a spare device end on a
   hand-driven bus for broken sequences. assumes design files first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %0t %h %h", $time, g, e); end end
module tb;
  import pair_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_we = 1'b0;
  logic req_first_hi = 1'b0;
  logic ready, done, wwe, we2, re2, rs2; // user-side ready level and pulses
  waddr_t req_addr = '0;
  waddr_t wao;
  word_t req_wdata = '0;
  word_t word_swap = '0;
  word_t rd_word, wwd, wd2, last2;
  word_t mem [4] = '{default: '0}; // word store behind the device
  wire word_t word_rdata = mem[wao[1:0]];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int cnt [3] = '{default: 0}; // spare end: commits, fetches, restarts
  host_port_if bus();
  host_port_if bus2();
  always #50 sys_clk = !sys_clk;
  host_port_host host_port_host_inst(.sys_clk(sys_clk), .rst(rst), .bus(bus), .req(req),
    .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_first_hi(req_first_hi), .ready(ready), .done(done), .rd_word(rd_word));
  host_port_device host_port_device_inst(.sys_clk(sys_clk), .rst(rst), .bus(bus),
    .word_swap(word_swap), .word_addr_out(wao), .word_wdata(wwd), .word_we(wwe),
    .word_re(), .word_rdata(word_rdata), .read_restart());
  host_port_device host_port_device_inst2(.sys_clk(sys_clk), .rst(rst), .bus(bus2),
    .word_swap(32'h00000000), .word_addr_out(), .word_wdata(wd2), .word_we(we2),
    .word_re(re2), .word_rdata(32'h89ab4567), .read_restart(rs2));
  host_port_chk host_port_chk_inst(.sys_clk(sys_clk), .rst(rst), .cs(bus.cs), .we(bus.we),
    .word_addr(bus.word_addr), .half_select_address_bit(bus.half_select_address_bit),
    .rdata(bus.rdata), .rvalid(bus.rvalid));
  // store, pulse counters and the hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (wwe === 1'b1) mem[wao[1:0]] <= wwd;
    if (we2 === 1'b1) last2 <= wd2;
    cnt[0] += (we2 === 1'b1);
    cnt[1] += (re2 === 1'b1);
    cnt[2] += (rs2 === 1'b1);
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  // one word access through the host end; waits end on the hang guard
  task automatic xfer(input logic w, input waddr_t a, input word_t d, input logic hi);
    @(posedge sys_clk);
    req <= 1'b1;
    req_we <= w;
    req_addr <= a;
    req_wdata <= d;
    req_first_hi <= hi;
    do @(negedge sys_clk); while (ready !== 1'b1);
    @(posedge sys_clk);
    req <= 1'b0;
    do @(negedge sys_clk); while (done !== 1'b1);
  endtask
  // write then read back, the read taking the other half first
  task automatic wr_rd(input word_t sw, input waddr_t a, input word_t d, input logic hi);
    @(posedge sys_clk);
    word_swap <= sw;
    xfer(1'b1, a, d, hi);
    repeat (2) @(negedge sys_clk);
    `CHK(mem[a[1:0]], (sw === 32'hffffffff) ? {d[15:0], d[31:16]} : d)
    xfer(1'b0, a, '0, !hi);
    `CHK(rd_word, d)
  endtask
  // one strobe on the spare bus; write data released to the inverse value
  task automatic acc2(input logic w, input logic sel, input half_t d);
    @(posedge sys_clk);
    bus2.cs <= 1'b1;
    bus2.we <= w;
    bus2.half_select_address_bit <= sel;
    bus2.wdata <= d;
    @(posedge sys_clk);
    bus2.cs <= 1'b0;
    bus2.wdata <= ~d;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // repeated halves: write dropped, read pairing restarted
  task automatic broken_host();
    acc2(1'b1, 1'b0, 16'h1111);
    acc2(1'b1, 1'b0, 16'h2222);
    acc2(1'b1, 1'b1, 16'h3333);
    `CHK(cnt[0], 1)
    `CHK(last2, 32'h33331111)
    acc2(1'b0, 1'b0, 16'h0000);
    acc2(1'b0, 1'b0, 16'h0000);
    `CHK(cnt[2], 1)
    acc2(1'b0, 1'b1, 16'h0000);
    `CHK(cnt[1], 2)
    `CHK(bus2.rdata, 16'h89ab)
    acc2(1'b0, 1'b0, 16'h0000);
    `CHK(bus2.rdata, 16'h4567)
  endtask
  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    bus2.cs = 1'b0;
    bus2.we = 1'b0;
    bus2.word_addr = 8'h05;
    bus2.half_select_address_bit = 1'b0;
    bus2.wdata = 16'h0000;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wr_rd(32'h00000000, 8'h01, 32'h12345678, 1'b0);
    wr_rd(32'hfffffffe, 8'h02, 32'hcafe0bee, 1'b1);
    wr_rd(32'hffffffff, 8'h03, 32'h0badf00d, 1'b0);
    wr_rd(32'hffffffff, 8'h04, 32'h5a5aa5a5, 1'b1);
    broken_host();
    final_report();
  end
endmodule // tb
`default_nettype wire
